// ### src/hpt_defines.vh
// Constants shared by the host-port flag and receive-output logic.
// Assumes a 25 MHz core clock that samples every pin through two flip-flops.
`ifndef HPT_DEFINES_VH
`define HPT_DEFINES_VH

// ----------------------------------------------------------------------------
// Transmit buffer geometry
// ----------------------------------------------------------------------------
`define HPT_TX_DEPTH        256
`define HPT_TX_CNT_W        9
`define HPT_TX_HALF_LEVEL   9'h080
`define HPT_TX_CNT_RST      9'h000

// ----------------------------------------------------------------------------
// Clear and self-test timing
// ----------------------------------------------------------------------------
`define HPT_CLR_EDGES       3'h7
`define HPT_CLR_DONE_CYC    8'h04
`define HPT_SEQ_LEN         9'h1ff
`define HPT_SEQ_RST         9'h000

// ----------------------------------------------------------------------------
// Receive side
// ----------------------------------------------------------------------------
`define HPT_RX_W            8
`define HPT_RX_HALF_CYC     8'h04
`define HPT_RX_DATA_RST     8'h00

`endif

// ### src/hpt_sync_edge.v
// Two-flop synchronisers with rising-edge detection for a group of pins.
// Assumes each pin is asynchronous to core_clk_i.
`timescale 1ns/1ps
module hpt_sync_edge #(
   parameter W = 1
) (
   input  wire         core_clk_i,
   input  wire         rst_i,
   input  wire [W-1:0] pin_i,
   output wire [W-1:0] level_o,
   output wire [W-1:0] rise_o
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;
   reg [W-1:0] prev_q;

   // -------------------------------------------------------------------------
   // Synchroniser chain
   // -------------------------------------------------------------------------
   // The edge detector looks only at the second and third stages, never at
   // the metastable first stage.
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         always @(posedge core_clk_i or posedge rst_i) begin
            if (rst_i) begin
               meta_q[g] <= 1'b0;
               sync_q[g] <= 1'b0;
               prev_q[g] <= 1'b0;
            end else begin
               meta_q[g] <= pin_i[g];
               sync_q[g] <= meta_q[g];
               prev_q[g] <= sync_q[g];
            end
         end
      end
   endgenerate

   assign level_o = sync_q;
   assign rise_o  = sync_q & ~prev_q;
endmodule // hpt_sync_edge

// ### src/hpt_buf2.v
// Two-entry first-in first-out buffer with valid/ready on both sides.
// Assumes both sides run on core_clk_i.
`timescale 1ns/1ps
module hpt_buf2 #(
   parameter W = 8
) (
   input  wire         core_clk_i,
   input  wire         rst_i,
   input  wire         in_valid_i,
   output wire         in_ready_o,
   input  wire [W-1:0] in_data_i,
   output wire         out_valid_o,
   input  wire         out_ready_i,
   output wire [W-1:0] out_data_o
);
   reg [W-1:0] head_q;
   reg [W-1:0] tail_q;
   reg [1:0]   cnt_q;
   wire        push;
   wire        pop;

   assign in_ready_o  = (cnt_q != 2'h2);
   assign out_valid_o = (cnt_q != 2'h0);
   assign out_data_o  = head_q;
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_ready_i & out_valid_o;

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         head_q <= {W{1'b0}};
         tail_q <= {W{1'b0}};
         cnt_q  <= 2'h0;
      end else begin
         if (push && !pop)
            cnt_q <= cnt_q + 2'h1;
         else if (pop && !push)
            cnt_q <= cnt_q - 2'h1;
         if (pop) begin
            head_q <= (cnt_q == 2'h2) ? tail_q : in_data_i;
            if (push && cnt_q == 2'h2)
               tail_q <= in_data_i;
         end else if (push) begin
            if (cnt_q == 2'h0)
               head_q <= in_data_i;
            else
               tail_q <= in_data_i;
         end
      end
   end
endmodule // hpt_buf2

// ### src/hpt_host_port.v
// Host-port status flags of the transmit buffer and the receive clock/data outputs.
// Assumes all pins are asynchronous; encoder and decoder strobes are core_clk_i logic.
`timescale 1ns/1ps
`include "hpt_defines.vh"
module hpt_host_port #(
   parameter TX_DEPTH   = `HPT_TX_DEPTH,
   parameter RX_W       = `HPT_RX_W
) (
   input  wire            core_clk_i,
   input  wire            rst_i,
   input  wire            tx_host_clock_i,
   input  wire            reference_clock_i,
   input  wire            chip_sel_n_i,
   input  wire            tx_write_enable_i,
   input  wire            tx_buffer_clear_n_i,
   input  wire            buffer_bypass_sel_i,
   input  wire            tx_selftest_enable_n_i,
   input  wire            external_buffer_mode_i,
   input  wire            codec_bypass_i,
   input  wire            rx_output_enable_i,
   input  wire            rx_host_clock_i,
   output wire            rx_host_clock_o,
   output wire            rx_host_clock_oe_n_o,
   input  wire            enc_read_i,
   input  wire            enc_char_tick_i,
   input  wire            tx_accept_i,
   output wire            tx_char_avail_o,
   input  wire            rx_char_valid_i,
   output wire            rx_char_ready_o,
   input  wire            rx_char_is_cmd_i,
   input  wire [RX_W-1:0] rx_char_decoded_i,
   input  wire [RX_W-1:0] rx_char_raw_i,
   output wire            tx_half_flag_o,
   output wire            tx_half_flag_oe_n_o,
   output wire            tx_empty_flag_o,
   output wire            tx_empty_flag_oe_n_o,
   output wire [RX_W-1:0] rx_word_out_o,
   output wire            rx_word_out_oe_n_o
);
   localparam CW = `HPT_TX_CNT_W;

   // -------------------------------------------------------------------------
   // Pin synchronisation
   // -------------------------------------------------------------------------
   wire [10:0] pin_lvl;
   wire [10:0] pin_rise;

   hpt_sync_edge #(.W(11)) u_sync (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .pin_i      ({rx_host_clock_i, rx_output_enable_i, codec_bypass_i,
                    external_buffer_mode_i, tx_selftest_enable_n_i,
                    buffer_bypass_sel_i, tx_buffer_clear_n_i, tx_write_enable_i,
                    chip_sel_n_i, reference_clock_i, tx_host_clock_i}),
      .level_o    (pin_lvl),
      .rise_o     (pin_rise)
   );

   wire tx_rise   = pin_rise[0];
   wire ref_rise  = pin_rise[1];
   wire cs_n_s    = pin_lvl[2];
   wire wr_en_s   = pin_lvl[3];
   wire clr_n_s   = pin_lvl[4];
   wire buf_en    = pin_lvl[5];
   wire st_on     = ~pin_lvl[6];
   wire ext_mode  = pin_lvl[7];
   wire dec_on    = pin_lvl[8];
   wire rx_en_s   = pin_lvl[9];
   wire rxin_rise = pin_rise[10];

   // Enables follow external mode polarity, like the empty flag; the half flag is active high in both modes.
   function act_level;
      input level;
      input ext;
      begin
         act_level = ext ? level : ~level;
      end
   endfunction

   wire wr_act = act_level(wr_en_s, ext_mode);
   wire rx_act = act_level(rx_en_s, ext_mode);

   // -------------------------------------------------------------------------
   // Transmit buffer occupancy and selection
   // -------------------------------------------------------------------------
   reg [CW-1:0] tx_cnt_q;
   reg          tx_cs_prev_q;
   reg          tx_wr_pend_q;
   reg [2:0]    clr_cnt_q;
   reg          clr_q;
   reg [7:0]    clr_done_q;
   wire         wr_now;
   wire         tx_write;
   wire         tx_read;

   assign wr_now   = wr_act & tx_cs_prev_q;
   // External mode takes the word one edge after the enable is seen.
   assign tx_write = tx_rise & buf_en & ~clr_q & (ext_mode ? tx_wr_pend_q : wr_now)
                     & (tx_cnt_q != TX_DEPTH[CW-1:0]);
   assign tx_read  = enc_read_i & buf_en & ~clr_q & ~st_on
                     & (tx_cnt_q != `HPT_TX_CNT_RST);
   assign tx_char_avail_o = buf_en & ~clr_q & ~st_on & (tx_cnt_q != `HPT_TX_CNT_RST);

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_cnt_q     <= `HPT_TX_CNT_RST;
         tx_cs_prev_q <= 1'b0;
         tx_wr_pend_q <= 1'b0;
      end else begin
         if (tx_rise) begin
            tx_cs_prev_q <= ~cs_n_s;
            tx_wr_pend_q <= wr_now;
         end
         if (clr_q)
            tx_cnt_q <= `HPT_TX_CNT_RST;
         else if (tx_write && !tx_read)
            tx_cnt_q <= tx_cnt_q + {{(CW-1){1'b0}}, 1'b1};
         else if (tx_read && !tx_write)
            tx_cnt_q <= tx_cnt_q - {{(CW-1){1'b0}}, 1'b1};
      end
   end

   // -------------------------------------------------------------------------
   // Transmit buffer clear
   // -------------------------------------------------------------------------
   // The clear holds while its pin stays low, then lets a short settling
   // count pass so both sides of the buffer are back at zero.
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         clr_cnt_q  <= 3'h0;
         clr_q      <= 1'b0;
         clr_done_q <= 8'h00;
      end else begin
         if (!buf_en) begin
            clr_cnt_q <= 3'h0;
         end else if (tx_rise) begin
            if (!wr_act && !cs_n_s && !clr_n_s) begin
               if (clr_cnt_q != `HPT_CLR_EDGES)
                  clr_cnt_q <= clr_cnt_q + 3'h1;
            end else begin
               clr_cnt_q <= 3'h0;
            end
         end
         if (buf_en && tx_rise && !wr_act && !cs_n_s && !clr_n_s
             && clr_cnt_q == `HPT_CLR_EDGES - 3'h1) begin
            clr_q      <= 1'b1;
            clr_done_q <= 8'h00;
         end else if (clr_q) begin
            if (!clr_n_s)
               clr_done_q <= 8'h00;
            else if (clr_done_q == `HPT_CLR_DONE_CYC)
               clr_q <= 1'b0;
            else
               clr_done_q <= clr_done_q + 8'h01;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Self-test sequence position
   // -------------------------------------------------------------------------
   reg [8:0] seq_q;
   reg       seq_end_q;
   wire      flag_edge;
   wire      seq_wrap;

   assign flag_edge = buf_en ? tx_rise : ref_rise;
   assign seq_wrap  = st_on & enc_char_tick_i & (seq_q == `HPT_SEQ_LEN - 9'h001);

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         seq_q     <= `HPT_SEQ_RST;
         seq_end_q <= 1'b0;
      end else begin
         if (!st_on)
            seq_q <= `HPT_SEQ_RST;
         else if (enc_char_tick_i)
            seq_q <= seq_wrap ? `HPT_SEQ_RST : seq_q + 9'h001;
         // A wrap in the cycle of the flag edge survives the consume.
         if (seq_wrap)
            seq_end_q <= 1'b1;
         else if (flag_edge || !st_on)
            seq_end_q <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // Flag registers
   // -------------------------------------------------------------------------
   reg half_q;
   reg empty_pin_q;
   reg empty_oe_n_q;
   reg empty_act;

   always @* begin
      if (st_on)
         empty_act = seq_end_q;
      else if (!buf_en)
         empty_act = tx_accept_i;
      else if (clr_q)
         empty_act = 1'b0;
      else
         empty_act = ~cs_n_s & (tx_cnt_q == `HPT_TX_CNT_RST);
   end

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         half_q       <= 1'b0;
         empty_pin_q  <= 1'b0;
         empty_oe_n_q <= 1'b1;
      end else if (flag_edge) begin
         half_q       <= buf_en & (clr_q
                         | (~cs_n_s & (tx_cnt_q >= `HPT_TX_HALF_LEVEL)));
         empty_pin_q  <= act_level(empty_act, ext_mode);
         empty_oe_n_q <= cs_n_s;
      end
   end

   assign tx_half_flag_o       = half_q;
   assign tx_half_flag_oe_n_o  = rst_i;
   assign tx_empty_flag_o      = empty_pin_q;
   assign tx_empty_flag_oe_n_o = empty_oe_n_q;

   // -------------------------------------------------------------------------
   // Receive character clock
   // -------------------------------------------------------------------------
   // The character clock runs free at all times so a bypassed host always sees
   // edges; the pin carries it only while the buffers are bypassed.
   reg       rx_host_clock_q;
   reg [7:0] rx_host_clock_cnt_q;
   reg       own_rise_q;
   wire      rx_edge;

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_host_clock_q     <= 1'b0;
         rx_host_clock_cnt_q <= 8'h00;
         own_rise_q  <= 1'b0;
      end else begin
         own_rise_q <= 1'b0;
         if (rx_host_clock_cnt_q == `HPT_RX_HALF_CYC) begin
            rx_host_clock_q     <= ~rx_host_clock_q;
            rx_host_clock_cnt_q <= 8'h00;
            own_rise_q  <= ~rx_host_clock_q;
         end else begin
            rx_host_clock_cnt_q <= rx_host_clock_cnt_q + 8'h01;
         end
      end
   end

   assign rx_host_clock_o      = rx_host_clock_q;
   assign rx_host_clock_oe_n_o = buf_en;
   assign rx_edge              = buf_en ? rxin_rise : own_rise_q;

   // -------------------------------------------------------------------------
   // Receive data path
   // -------------------------------------------------------------------------
   wire              bo_valid;
   wire [2*RX_W:0]   bo_data;
   reg               rx_cs_prev_q;
   reg               rx_sel_q;
   reg               rx_oe_n_q;
   reg  [RX_W-1:0]   rx_word_q;
   wire              rx_pop;

   assign rx_pop = rx_edge & rx_sel_q & bo_valid;

   hpt_buf2 #(.W(2*RX_W+1)) u_rxbuf (
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (rx_char_valid_i),
      .in_ready_o  (rx_char_ready_o),
      .in_data_i   ({rx_char_is_cmd_i, rx_char_decoded_i, rx_char_raw_i}),
      .out_valid_o (bo_valid),
      .out_ready_i (rx_pop),
      .out_data_o  (bo_data)
   );

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_cs_prev_q <= 1'b0;
         rx_sel_q     <= 1'b0;
         rx_oe_n_q    <= 1'b1;
         rx_word_q    <= `HPT_RX_DATA_RST;
      end else if (rx_edge) begin
         rx_cs_prev_q <= ~cs_n_s;
         rx_sel_q     <= rx_act & rx_cs_prev_q;
         rx_oe_n_q    <= ~(rx_act & rx_cs_prev_q);
         if (rx_pop) begin
            if (!dec_on)
               rx_word_q <= bo_data[RX_W-1:0];
            else if (!bo_data[2*RX_W])
               rx_word_q <= bo_data[2*RX_W-1:RX_W];
         end
      end
   end

   assign rx_word_out_o      = rx_word_q;
   assign rx_word_out_oe_n_o = rx_oe_n_q;
endmodule // hpt_host_port

// ### tb/hpt_host_port_asserts.sv
// Concurrent checks on the host-port status flags and the receive clock and output pins.
// Assumes pin clocks of 320 ns against a 40 ns core clock: one flag period is 8 core cycles.
`timescale 1ns/1ps
module hpt_host_port_asserts (
   input wire       core_clk_i,
   input wire       rst_i,
   input wire       chip_sel_n_i,
   input wire       tx_write_enable_i,
   input wire       tx_buffer_clear_n_i,
   input wire       buffer_bypass_sel_i,
   input wire       tx_selftest_enable_n_i,
   input wire       external_buffer_mode_i,
   input wire       rx_output_enable_i,
   input wire       rx_host_clock_o,
   input wire       rx_host_clock_oe_n_o,
   input wire       tx_half_flag_o,
   input wire       tx_half_flag_oe_n_o,
   input wire       tx_empty_flag_o,
   input wire       tx_empty_flag_oe_n_o,
   input wire       rx_word_out_oe_n_o
);
   // ----------------------------------------------------------------------
   // Run-length counters
   // ----------------------------------------------------------------------
   // Pins pass a synchroniser and wait for a flag edge, so each check waits
   // for its cause to stand long enough; the margins cover both delays.
   wire       wr_off = (tx_write_enable_i != external_buffer_mode_i);
   wire       flag_on = (tx_empty_flag_o == external_buffer_mode_i);
   wire [5:0] cond = {!tx_selftest_enable_n_i,
                      buffer_bypass_sel_i & (rx_output_enable_i != external_buffer_mode_i),
                      !tx_buffer_clear_n_i & !chip_sel_n_i & buffer_bypass_sel_i
                         & tx_selftest_enable_n_i & wr_off,
                      !chip_sel_n_i, chip_sel_n_i, !buffer_bypass_sel_i};
   reg  [7:0] run_q [0:5];
   integer    i;

   always @(posedge core_clk_i or posedge rst_i) begin
      for (i = 0; i < 6; i = i + 1) begin
         if (rst_i) run_q[i] <= 8'h00;
         else if (!cond[i]) run_q[i] <= 8'h00;
         else if (run_q[i] != 8'hff) run_q[i] <= run_q[i] + 8'h01;
      end
   end

   a_half_driven: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !tx_half_flag_oe_n_o) else $error("half flag undriven outside reset");
   a_half_bypass: assert property (@(posedge core_clk_i) disable iff (rst_i)
      run_q[0] >= 8'd20 |-> !tx_half_flag_o) else $error("half flag set while bypassed");
   a_empty_hiz: assert property (@(posedge core_clk_i) disable iff (rst_i)
      run_q[1] >= 8'd16 |-> tx_empty_flag_oe_n_o) else $error("empty flag driven, deselected");
   a_empty_drive: assert property (@(posedge core_clk_i) disable iff (rst_i)
      run_q[2] >= 8'd16 |-> !tx_empty_flag_oe_n_o) else $error("empty flag not driven");
   a_half_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
      run_q[3] >= 8'd72 |-> tx_half_flag_o) else $error("half flag low during clear");
   a_empty_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
      run_q[3] >= 8'd72 |-> !flag_on) else $error("empty flag asserted during clear");
   a_rx_out_hiz: assert property (@(posedge core_clk_i) disable iff (rst_i)
      run_q[4] >= 8'd24 |-> rx_word_out_oe_n_o) else $error("receive word driven, disabled");
   a_rx_host_clock_dir: assert property (@(posedge core_clk_i) disable iff (rst_i)
      run_q[0] >= 8'd5 |-> !rx_host_clock_oe_n_o) else $error("receive clock not driven");
   a_rx_host_clock_pulse: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !rx_host_clock_oe_n_o && $rose(rx_host_clock_o) |-> rx_host_clock_o [*5] ##1
      !rx_host_clock_o) else $error("receive clock high phase wrong");
   a_st_pulse: assert property (@(posedge core_clk_i) disable iff (rst_i)
      run_q[5] >= 8'd20 && $rose(flag_on) |-> flag_on [*8] ##1 !flag_on)
      else $error("self-test pulse not one flag period");
endmodule // hpt_host_port_asserts

bind hpt_host_port hpt_host_port_asserts u_asserts (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .chip_sel_n_i(chip_sel_n_i),
   .tx_write_enable_i(tx_write_enable_i), .tx_buffer_clear_n_i(tx_buffer_clear_n_i),
   .buffer_bypass_sel_i(buffer_bypass_sel_i), .tx_selftest_enable_n_i(tx_selftest_enable_n_i),
   .external_buffer_mode_i(external_buffer_mode_i), .rx_output_enable_i(rx_output_enable_i),
   .rx_host_clock_o(rx_host_clock_o), .rx_host_clock_oe_n_o(rx_host_clock_oe_n_o),
   .tx_half_flag_o(tx_half_flag_o), .tx_half_flag_oe_n_o(tx_half_flag_oe_n_o),
   .tx_empty_flag_o(tx_empty_flag_o), .tx_empty_flag_oe_n_o(tx_empty_flag_oe_n_o),
   .rx_word_out_oe_n_o(rx_word_out_oe_n_o));

// ### tb/hpt_host_model.sv
// Host-side model: free-running pin clocks and the shared receive-clock pin.
// Assumes the device drives the receive-clock pin only while its enable is low.
`timescale 1ns/1ps
module hpt_host_model (
   input  wire rx_dev_clk_i,
   input  wire rx_dev_oe_n_i,
   output reg  tx_clk_o,
   output reg  ref_clk_o,
   output reg  rx_host_clk_o,
   output wire rx_pin_o
);
   // Odd start offsets keep the three clocks out of phase with the core clock.
   initial begin
      tx_clk_o = 1'b0;
      #13;
      forever #160 tx_clk_o = ~tx_clk_o;
   end
   initial begin
      ref_clk_o = 1'b0;
      #71;
      forever #160 ref_clk_o = ~ref_clk_o;
   end
   initial begin
      rx_host_clk_o = 1'b0;
      #157;
      forever #160 rx_host_clk_o = ~rx_host_clk_o;
   end
   assign rx_pin_o = rx_dev_oe_n_i ? rx_host_clk_o : rx_dev_clk_i;
endmodule // hpt_host_model

// ### tb/hpt_host_port_tb_top.sv
// Self-checking bench for the host-port flags and the receive word outputs.
// Assumes the host model supplies the pin clocks; inputs change on falling core edges.
`timescale 1ns/1ps
module hpt_host_port_tb_top;
   reg         core_clk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg         cs_n = 1'b0, we = 1'b1, clr_n = 1'b1, sel = 1'b1, st_n = 1'b1, mode = 1'b0;
   reg         codec = 1'b1, rx_en = 1'b1, tick = 1'b0, acc = 1'b0, vld = 1'b0, is_cmd = 1'b0;
   reg  [7:0]  dec = 8'h00, raw = 8'h00, last_w = 8'h00, last_exp = 8'h00;
   reg  [15:0] seed = 16'h8e68;
   wire        tx_clk, ref_clk, rx_hclk, rx_pin, rxc_o, rxc_oe_n, rdy;
   wire        half, half_oe_n, emp, emp_oe_n, word_oe_n, avail;
   wire [7:0]  word;
   logic [7:0] exp_q [$];
   int         num_errors = 0, samples_checked = 0, cycles = 0, st_pulses = 0, rx_age = 0, k;
   reg         emp_d = 1'b0, rx_d = 1'b0, rd = 1'b0;

   always #20 core_clk_i = ~core_clk_i;

   hpt_host_model u_host (.rx_dev_clk_i(rxc_o), .rx_dev_oe_n_i(rxc_oe_n), .tx_clk_o(tx_clk),
      .ref_clk_o(ref_clk), .rx_host_clk_o(rx_hclk), .rx_pin_o(rx_pin));

   hpt_host_port DUT (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .tx_host_clock_i(tx_clk),
      .reference_clock_i(ref_clk), .chip_sel_n_i(cs_n), .tx_write_enable_i(we),
      .tx_buffer_clear_n_i(clr_n), .buffer_bypass_sel_i(sel), .tx_selftest_enable_n_i(st_n),
      .external_buffer_mode_i(mode), .codec_bypass_i(codec), .rx_output_enable_i(rx_en),
      .rx_host_clock_i(rx_pin), .rx_host_clock_o(rxc_o), .rx_host_clock_oe_n_o(rxc_oe_n),
      .enc_read_i(rd), .enc_char_tick_i(tick), .tx_accept_i(acc), .tx_char_avail_o(avail),
      .rx_char_valid_i(vld), .rx_char_ready_o(rdy), .rx_char_is_cmd_i(is_cmd),
      .rx_char_decoded_i(dec), .rx_char_raw_i(raw), .tx_half_flag_o(half),
      .tx_half_flag_oe_n_o(half_oe_n), .tx_empty_flag_o(emp), .tx_empty_flag_oe_n_o(emp_oe_n),
      .rx_word_out_o(word), .rx_word_out_oe_n_o(word_oe_n));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic wrap_up;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic chk1(input logic seen, input logic exp);
      chk({7'h00, seen}, {7'h00, exp});
   endtask

   // Ends two core falling edges after the pin falls following the last rising edge, so pin changes never race an edge.
   task automatic tx_wait(input int n);
      repeat (n) @(posedge tx_clk);
      @(negedge tx_clk);
      repeat (2) @(negedge core_clk_i);
   endtask

   task automatic wr(input int n);
      we = mode;
      tx_wait(n);
      we = ~mode;
      tx_wait(1);
   endtask

   task automatic ticks(input int n);
      repeat (n) begin
         tick = 1'b1;
         @(negedge core_clk_i) tick = 1'b0;
         @(negedge core_clk_i);
      end
      repeat (20) @(negedge core_clk_i);
   endtask

   // Valid stays up across back-to-back pushes; the caller drops it at the end.
   task automatic push(input logic cmd);
      logic [7:0] v;
      seed = lfsr(seed);
      v = (seed[7:0] == last_exp) ? ~seed[7:0] : seed[7:0];
      vld = 1'b1;
      is_cmd = cmd;
      dec = codec ? v : seed[15:8];
      raw = codec ? seed[15:8] : v;
      if (!(cmd && codec)) begin
         exp_q.push_back(v);
         last_exp = v;
      end
      @(posedge core_clk_i);
      while (rdy !== 1'b1) @(posedge core_clk_i);
      @(negedge core_clk_i);
   endtask

   always @(posedge core_clk_i) begin
      cycles++;
      emp_d <= emp;
      rx_d <= rx_pin;
      rx_age = (rx_pin && !rx_d) ? 0 : rx_age + 1;
      if (!st_n && emp_d && !emp) st_pulses <= st_pulses + 1;
      if (!rst_i && word !== last_w) begin
         last_w = word;
         chk1(rx_age <= 5, 1'b1);
         chk(word, (exp_q.size() != 0) ? exp_q.pop_front() : ~word);
      end
      if (cycles == 20000) begin
         num_errors++;
         wrap_up;
      end
   end

   initial begin
      repeat (5) @(posedge core_clk_i);
      chk1(half_oe_n, 1'b1);
      @(negedge core_clk_i) rst_i = 1'b0;
      tx_wait(3);
      chk1(emp, 1'b0);
      chk1(emp_oe_n, 1'b0);
      mode = 1'b1;
      we = 1'b0;
      rx_en = 1'b0;
      tx_wait(2);
      chk1(emp, 1'b1);
      mode = 1'b0;
      we = 1'b1;
      rx_en = 1'b1;
      wr(127);
      chk1(half, 1'b0);
      chk1(emp, 1'b1);
      wr(1);
      chk1(half, 1'b1);
      chk1(avail, 1'b1);
      rd = 1'b1;
      @(negedge core_clk_i) rd = 1'b0;
      tx_wait(1);
      chk1(half, 1'b0);
      chk1(avail, 1'b1);
      clr_n = 1'b0;
      tx_wait(9);
      chk1(half, 1'b1);
      chk1(emp, 1'b1);
      clr_n = 1'b1;
      tx_wait(3);
      chk1(half, 1'b0);
      chk1(emp, 1'b0);
      chk1(avail, 1'b0);
      clr_n = 1'b0;
      tx_wait(6);
      chk1(emp, 1'b0);
      clr_n = 1'b1;
      cs_n = 1'b1;
      tx_wait(3);
      chk1(emp_oe_n, 1'b1);
      cs_n = 1'b0;
      sel = 1'b0;
      repeat (10) @(negedge core_clk_i);
      chk1(rxc_oe_n, 1'b0);
      for (k = 0; k < 6; k++) begin
         seed = lfsr(seed);
         acc = seed[0];
         @(posedge ref_clk);
         repeat (5) @(negedge core_clk_i);
         chk1(emp, ~acc);
         chk1(half, 1'b0);
      end
      acc = 1'b1;
      st_n = 1'b0;
      repeat (20) @(negedge core_clk_i);
      st_pulses = 0;
      ticks(510);
      chk(st_pulses[7:0], 8'h00);
      ticks(1);
      chk(st_pulses[7:0], 8'h01);
      st_n = 1'b1;
      sel = 1'b1;
      rx_en = 1'b0;
      tx_wait(2);
      for (k = 0; k < 8; k++) push(k % 3 == 2);
      vld = 1'b0;
      repeat (40) @(negedge core_clk_i);
      chk1(word_oe_n, 1'b0);
      rx_en = 1'b1;
      repeat (30) @(negedge core_clk_i);
      chk1(word_oe_n, 1'b1);
      rx_en = 1'b0;
      codec = 1'b0;
      for (k = 0; k < 4; k++) push(k[0]);
      vld = 1'b0;
      repeat (40) @(negedge core_clk_i);
      sel = 1'b0;
      repeat (10) @(negedge core_clk_i);
      for (k = 0; k < 4; k++) push(1'b0);
      vld = 1'b0;
      repeat (60) @(negedge core_clk_i);
      chk(exp_q.size(), 8'h00);
      wrap_up;
   end
endmodule // hpt_host_port_tb_top
